// ==== core/tap_bscan_pkg.sv ====
// constants and types for the boundary scan control block
package tap_bscan_pkg;
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_t;

    localparam int IR_W = 4;
    localparam int CHAIN_W = 5;
    localparam int ID_W = 32;
    localparam int NUM_STROBES = 3;
    // strobe index positions
    localparam int STB_EXT = 0;
    localparam int STB_INT = 1;
    localparam int STB_UPD = 2;
    // instruction codes; fixed here, the set is not a parameter of the design
    localparam logic [IR_W-1:0] INSTR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INSTR_SCAN_N = 4'h2;
    localparam logic [IR_W-1:0] INSTR_CLAMP = 4'h5;
    localparam logic [IR_W-1:0] INSTR_CLAMPZ = 4'h9;
    localparam logic [IR_W-1:0] INSTR_INTEST = 4'hc;
    localparam logic [IR_W-1:0] INSTR_IDCODE = 4'he;
    localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hf;
    // the external boundary chain number
    localparam logic [CHAIN_W-1:0] BSCAN_CHAIN = 5'h03;
    // values after reset, and the instruction capture value
    localparam logic [IR_W-1:0] IR_RESET_VAL = 4'he;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
    localparam logic [CHAIN_W-1:0] CHAIN_RESET_VAL = 5'h00;
    // arbitrary identification value, names no maker
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001;
    localparam int SYNC_STAGES = 2;
endpackage

// ==== core/tap_boundary_scan_ctrl.sv ====
// test access port controller with external boundary chain strobes
`timescale 1ns/1ps
module tap_boundary_scan_ctrl
    import tap_bscan_pkg::*;
#(
    parameter logic [ID_W-1:0] DEVICE_ID = tap_bscan_pkg::ID_VALUE
)(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_en,
    input wire logic chain_serial_return,
    output logic chain_serial_out,
    output logic scan_cell_mux_enable,
    output logic extest_capture_strobe,
    output logic intest_capture_strobe,
    output logic chain_update_strobe,
    output logic chain_reset_out,
    output logic [tap_bscan_pkg::IR_W-1:0] tap_instr_code_out,
    output logic [tap_bscan_pkg::CHAIN_W-1:0] selected_chain_id,
    output logic core_chain_reset,
    output logic core_boundary_active
);
    import tap_bscan_pkg::*;

    tap_state_t state_reg;
    tap_state_t state_next;
    logic [IR_W-1:0] ir_shift_reg;
    logic [IR_W-1:0] ir_reg;
    logic [CHAIN_W-1:0] chain_shift_reg;
    logic [CHAIN_W-1:0] chain_reg;
    logic [ID_W-1:0] id_shift_reg;
    logic bypass_reg;
    logic tdo_reg;
    logic tdo_en_reg;
    logic serial_out_reg;
    logic mux_en_reg;
    logic chain_reset_reg;
    logic on_chain;
    logic boundary_dr;
    logic dr_bit;
    logic [NUM_STROBES-1:0] strobe_cond;
    logic [NUM_STROBES-1:0] strobe_pulse;
    logic [SYNC_STAGES-1:0] rst_sync_reg;
    logic [SYNC_STAGES-1:0] act_sync_reg;

    // tap state sequence
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET: state_next = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_next = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            state_reg <= ST_RESET;
        else
            state_reg <= state_next;
    end

    // held high through the test reset and the whole reset state
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            chain_reset_reg <= 1'b1;
        else
            chain_reset_reg <= (state_next == ST_RESET);
    end

    // instruction shift path
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            ir_shift_reg <= IR_RESET_VAL;
        else if (state_reg == ST_CAP_IR)
            ir_shift_reg <= IR_CAPTURE_VAL;
        else if (state_reg == ST_SHIFT_IR)
            ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
    end

    assign on_chain = (chain_reg == BSCAN_CHAIN);
    assign boundary_dr = on_chain && (ir_reg == INSTR_EXTEST || ir_reg == INSTR_INTEST);

    // data shift paths; the boundary path itself lives outside in the chain
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            chain_shift_reg <= CHAIN_RESET_VAL;
            id_shift_reg <= '0;
            bypass_reg <= 1'b0;
        end
        else if (state_reg == ST_CAP_DR)
        begin
            chain_shift_reg <= chain_reg;
            id_shift_reg <= DEVICE_ID;
            bypass_reg <= 1'b0;
        end
        else if (state_reg == ST_SHIFT_DR)
        begin
            chain_shift_reg <= {tdi, chain_shift_reg[CHAIN_W-1:1]};
            id_shift_reg <= {tdi, id_shift_reg[ID_W-1:1]};
            bypass_reg <= tdi;
        end
    end

    // chain data is taken at the falling edge, so it must be settled by then
    always_comb
    begin
        if (boundary_dr)
            dr_bit = chain_serial_return;
        else if (ir_reg == INSTR_SCAN_N)
            dr_bit = chain_shift_reg[0];
        else if (ir_reg == INSTR_IDCODE)
            dr_bit = id_shift_reg[0];
        else
            dr_bit = bypass_reg;
    end

    // serial output leaves on the falling edge per usual tap timing
    always_ff @(negedge tck or negedge trst_n)
    begin
        if (!trst_n)
        begin
            tdo_reg <= 1'b0;
            tdo_en_reg <= 1'b0;
        end
        else
        begin
            tdo_reg <= (state_reg == ST_SHIFT_IR) ? ir_shift_reg[0] : dr_bit;
            tdo_en_reg <= (state_reg == ST_SHIFT_IR) || (state_reg == ST_SHIFT_DR);
        end
    end

    // launched at the rising edge so it sits still across the falling edge
    always_ff @(posedge tck or negedge trst_n)
    begin
        if (!trst_n)
            serial_out_reg <= 1'b0;
        else
            serial_out_reg <= tdi;
    end

    always_ff @(negedge tck or negedge trst_n)
    begin
        if (!trst_n)
            ir_reg <= IR_RESET_VAL;
        else if (state_reg == ST_UPD_IR)
            ir_reg <= ir_shift_reg;
    end

    always_ff @(negedge tck or negedge trst_n)
    begin
        if (!trst_n)
            chain_reg <= CHAIN_RESET_VAL;
        else if (state_reg == ST_UPD_DR && ir_reg == INSTR_SCAN_N)
            chain_reg <= chain_shift_reg;
    end

    // judged against the incoming instruction and the chain already chosen
    always_ff @(negedge tck or negedge trst_n)
    begin
        if (!trst_n)
            mux_en_reg <= 1'b0;
        else if (state_reg == ST_UPD_IR)
            mux_en_reg <= on_chain && (ir_shift_reg == INSTR_INTEST || ir_shift_reg == INSTR_EXTEST
                || ir_shift_reg == INSTR_CLAMP || ir_shift_reg == INSTR_CLAMPZ);
    end

    assign strobe_cond[STB_EXT] = (state_reg == ST_CAP_DR) && on_chain && (ir_reg == INSTR_EXTEST);
    assign strobe_cond[STB_INT] = (state_reg == ST_CAP_DR) && on_chain && (ir_reg == INSTR_INTEST);
    assign strobe_cond[STB_UPD] = (state_reg == ST_UPD_DR) && on_chain;

    // a toggle on each edge; their difference is high from fall to rise only,
    // which gives a glitch-free low-phase pulse without gating the clock
    genvar gi;
    generate
        for (gi = 0; gi < NUM_STROBES; gi++)
        begin : g_strobe
            logic fall_tog_reg;
            logic rise_tog_reg;
            always_ff @(negedge tck or negedge trst_n)
            begin
                if (!trst_n)
                    fall_tog_reg <= 1'b0;
                else
                    fall_tog_reg <= fall_tog_reg ^ strobe_cond[gi];
            end
            always_ff @(posedge tck or negedge trst_n)
            begin
                if (!trst_n)
                    rise_tog_reg <= 1'b0;
                else
                    rise_tog_reg <= fall_tog_reg;
            end
            assign strobe_pulse[gi] = fall_tog_reg ^ rise_tog_reg;
        end
    endgenerate

    // core side copies of chain levels, two flops each
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rst_sync_reg <= '1;
            act_sync_reg <= '0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], chain_reset_reg};
            act_sync_reg <= {act_sync_reg[0], mux_en_reg};
        end
    end

    assign tdo = tdo_reg;
    assign tdo_en = tdo_en_reg;
    assign chain_serial_out = serial_out_reg;
    assign scan_cell_mux_enable = mux_en_reg;
    assign extest_capture_strobe = strobe_pulse[STB_EXT];
    assign intest_capture_strobe = strobe_pulse[STB_INT];
    assign chain_update_strobe = strobe_pulse[STB_UPD];
    assign chain_reset_out = chain_reset_reg;
    assign tap_instr_code_out = ir_reg;
    assign selected_chain_id = chain_reg;
    assign core_chain_reset = rst_sync_reg[1];
    assign core_boundary_active = act_sync_reg[1];

    sequence s_five_ones;
        tms [*5];
    endsequence

    property p_fsm_reset;
        @(posedge tck) disable iff (!trst_n) s_five_ones |=> state_reg == ST_RESET;
    endproperty
    a_fsm_reset: assert property (p_fsm_reset) else $error("five tms highs did not reach reset");

    property p_reset_out;
        @(posedge tck) disable iff (!trst_n) chain_reset_out == (state_reg == ST_RESET);
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("chain reset disagrees with state");

    sequence s_ir_update;
        state_reg == ST_UPD_IR;
    endsequence

    property p_instr_out;
        @(negedge tck) disable iff (!trst_n) s_ir_update |=> tap_instr_code_out == $past(ir_shift_reg);
    endproperty
    a_instr_out: assert property (p_instr_out) else $error("instruction not updated");

    property p_instr_hold;
        @(negedge tck) disable iff (!trst_n) state_reg != ST_UPD_IR |=> $stable(tap_instr_code_out);
    endproperty
    a_instr_hold: assert property (p_instr_hold) else $error("instruction moved outside update");

    property p_chain_id;
        @(negedge tck) disable iff (!trst_n)
            (state_reg == ST_UPD_DR && ir_reg == INSTR_SCAN_N) |=> selected_chain_id == $past(chain_shift_reg);
    endproperty
    a_chain_id: assert property (p_chain_id) else $error("chain id not updated");

    property p_mux_en;
        @(negedge tck) disable iff (!trst_n)
            (s_ir_update and (chain_reg != BSCAN_CHAIN)) |=> !scan_cell_mux_enable;
    endproperty
    a_mux_en: assert property (p_mux_en) else $error("cell enable set off chain");

    // the pulse is still high at the rising edge that closes the state it belongs to
    property p_ext_strobe;
        @(posedge tck) disable iff (!trst_n) ##1 extest_capture_strobe == strobe_cond[STB_EXT];
    endproperty
    a_ext_strobe: assert property (p_ext_strobe) else $error("extest strobe mismatch");

    property p_int_strobe;
        @(posedge tck) disable iff (!trst_n) ##1 intest_capture_strobe == strobe_cond[STB_INT];
    endproperty
    a_int_strobe: assert property (p_int_strobe) else $error("intest strobe mismatch");

    property p_upd_strobe;
        @(posedge tck) disable iff (!trst_n)
            chain_update_strobe |-> state_reg == ST_UPD_DR && (on_chain || ir_reg == INSTR_SCAN_N);
    endproperty
    a_upd_strobe: assert property (p_upd_strobe) else $error("update strobe off chain");

    property p_serial_out;
        @(posedge tck) disable iff (!trst_n) ##1 chain_serial_out == $past(tdi);
    endproperty
    a_serial_out: assert property (p_serial_out) else $error("serial data not forwarded");
endmodule

// ==== testbench/bscan_chain_model.sv ====
// behavioural external boundary cell chain driven by the capture strobes
`timescale 1ns/1ps
module bscan_chain_model
    import tap_bscan_pkg::*;
#(
    parameter int LEN = 8,
    parameter logic [LEN-1:0] PINS = 8'ha5
)(
    input wire logic tck,
    input wire logic chain_reset_out,
    input wire logic extest_capture_strobe,
    input wire logic intest_capture_strobe,
    input wire logic chain_serial_out,
    output logic chain_serial_return
);
    logic [LEN-1:0] cell_reg;
    // shifts just after a rising edge, so it is settled for the falling edge that samples it; capture loads at a falling edge
    assign chain_serial_return = cell_reg[0];
    // no shift on the rising edge that ends a capture pulse
    always @(posedge tck or posedge extest_capture_strobe or posedge intest_capture_strobe or posedge chain_reset_out)
    begin
        if (chain_reset_out)
            cell_reg <= '0;
        else if (extest_capture_strobe)
        begin
            if (!tck)
                cell_reg <= PINS;
        end
        else if (intest_capture_strobe)
        begin
            if (!tck)
                cell_reg <= ~PINS;
        end
        else if (tck)
            cell_reg <= {chain_serial_out, cell_reg[LEN-1:1]};
    end
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the boundary scan control block
`timescale 1ns/1ps
module tb_top;
    import tap_bscan_pkg::*;
    typedef struct {
        logic [IR_W-1:0] instr;
        logic mux;
        logic ext;
        logic intl;
        logic [7:0] cap;
    } row_t;
    localparam int LEN = 8;
    localparam logic [LEN-1:0] PINS = 8'ha5;
    logic core_clk = 1'b0;
    logic tck = 1'b0;
    logic srst = 1'b1;
    logic trst_n = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b0;
    logic tdi_q = 1'b0;
    logic chk_ser = 1'b0;
    logic chain_on = 1'b1;
    logic ret_in;
    logic tdo, tdo_en, ret, ser_out, mux_en, ext_stb, int_stb, upd_stb, rst_out, core_rst, core_act;
    logic [IR_W-1:0] instr_out;
    logic [CHAIN_W-1:0] chain_id;
    int n_fail = 0;
    int n_checks = 0;
    int n_ext = 0;
    int n_int = 0;
    int n_upd = 0;
    int cycles = 0;
    row_t rows [6];
    always #4 core_clk = ~core_clk;
    // link clock offset so its edges never meet the core clock edges
    initial
    begin
        #1.3;
        forever #3 tck = ~tck;
    end
    tap_boundary_scan_ctrl DUT (.core_clk(core_clk), .srst(srst), .tck(tck), .trst_n(trst_n), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_en(tdo_en), .chain_serial_return(ret_in), .chain_serial_out(ser_out),
        .scan_cell_mux_enable(mux_en), .extest_capture_strobe(ext_stb), .intest_capture_strobe(int_stb),
        .chain_update_strobe(upd_stb), .chain_reset_out(rst_out), .tap_instr_code_out(instr_out),
        .selected_chain_id(chain_id), .core_chain_reset(core_rst), .core_boundary_active(core_act));
    bscan_chain_model #(.LEN(LEN), .PINS(PINS)) chain_model (.tck(tck), .chain_reset_out(rst_out),
        .extest_capture_strobe(ext_stb), .intest_capture_strobe(int_stb), .chain_serial_out(ser_out),
        .chain_serial_return(ret));
    // with no chain fitted the return input is tied low
    assign ret_in = chain_on ? ret : 1'b0;
    always @(posedge ext_stb) n_ext++;
    always @(posedge int_stb) n_int++;
    always @(posedge upd_stb) n_upd++;
    always @(posedge tck) tdi_q <= tdi;
    always @(negedge tck)
        if (chk_ser) check_bit("chain_serial_out", tdi_q, ser_out);
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            $display("unexpected cycles expected below 5000 seen 5000");
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check_bit(input string what, input logic exp, input logic seen);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one test clock cycle; seen is tdo as left by the falling edge of this cycle
    task automatic step(input logic m, input logic d, output logic seen);
        tms <= m;
        tdi <= d;
        @(posedge tck);
        seen = tdo;
    endtask
    task automatic ir_scan(input logic [IR_W-1:0] code);
        logic t;
        step(1'b1, 1'b0, t);
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < IR_W; i++)
            step(i == IR_W - 1, code[i], t);
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask
    task automatic dr_scan(input int n, input logic [31:0] data, output logic [31:0] got);
        logic t;
        got = '0;
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, data[i], got[i]);
            check_bit("tdo_en", 1'b1, tdo_en);
        end
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
    endtask
    initial
    begin
        logic t;
        logic [31:0] got;
        int e0, i0, u0;
        rows[0] = '{INSTR_EXTEST, 1'b1, 1'b1, 1'b0, PINS};
        rows[1] = '{INSTR_INTEST, 1'b1, 1'b0, 1'b1, ~PINS};
        rows[2] = '{INSTR_CLAMP, 1'b1, 1'b0, 1'b0, 8'h00};
        rows[3] = '{INSTR_CLAMPZ, 1'b1, 1'b0, 1'b0, 8'h00};
        rows[4] = '{INSTR_BYPASS, 1'b0, 1'b0, 1'b0, 8'h00};
        rows[5] = '{INSTR_IDCODE, 1'b0, 1'b0, 1'b0, 8'h00};
        repeat (12) @(posedge core_clk);
        check_bit("chain_reset_out", 1'b1, rst_out);
        check_bit("core_chain_reset", 1'b1, core_rst);
        check_vec("tap_instr_code_out", IR_RESET_VAL, instr_out);
        check_vec("selected_chain_id", CHAIN_RESET_VAL, chain_id);
        srst <= 1'b0;
        @(posedge tck);
        trst_n <= 1'b1;
        repeat (3) step(1'b0, 1'b0, t);
        chk_ser = 1'b1;
        check_bit("chain_reset_out", 1'b0, rst_out);
        $display("reset test done");
        // chain 0 still selected: enable and strobes must stay quiet
        ir_scan(INSTR_EXTEST);
        check_bit("scan_cell_mux_enable", 1'b0, mux_en);
        u0 = n_upd;
        e0 = n_ext;
        dr_scan(LEN, 32'h0, got);
        check_vec("update pulses", u0, n_upd);
        check_vec("extest pulses", e0, n_ext);
        ir_scan(INSTR_SCAN_N);
        check_vec("tap_instr_code_out", INSTR_SCAN_N, instr_out);
        dr_scan(CHAIN_W, 32'h3, got);
        check_vec("selected_chain_id", BSCAN_CHAIN, chain_id);
        $display("chain select test done");
        foreach (rows[r])
        begin
            e0 = n_ext;
            i0 = n_int;
            u0 = n_upd;
            ir_scan(rows[r].instr);
            check_vec("tap_instr_code_out", rows[r].instr, instr_out);
            check_bit("scan_cell_mux_enable", rows[r].mux, mux_en);
            repeat (4) @(posedge core_clk);
            @(posedge tck);
            check_bit("core_boundary_active", rows[r].mux, core_act);
            dr_scan(LEN, 32'h0, got);
            check_vec("extest pulses", e0 + rows[r].ext, n_ext);
            check_vec("intest pulses", i0 + rows[r].intl, n_int);
            check_vec("update pulses", u0 + 1, n_upd);
            if (rows[r].ext || rows[r].intl)
                check_vec("captured cells", rows[r].cap, got);
            $display("row %0d test done", r);
        end
        chain_on <= 1'b0;
        ir_scan(INSTR_EXTEST);
        dr_scan(LEN, 32'h0, got);
        check_vec("unconnected chain data", 32'h0, got);
        check_bit("tdo_en", 1'b0, tdo_en);
        $display("no chain test done");
        repeat (6) step(1'b1, 1'b0, t);
        check_bit("chain_reset_out", 1'b1, rst_out);
        repeat (4) @(posedge core_clk);
        check_bit("core_chain_reset", 1'b1, core_rst);
        $display("tms reset test done");
        complete_run();
    end
endmodule
